/* core/snpi_pkg.sv */
package snpi_pkg;

   // Lane width codes for one byte of traffic.
   typedef enum logic [1:0] {
      SNPI_W_SINGLE = 2'b00,
      SNPI_W_DUAL   = 2'b01,
      SNPI_W_QUAD   = 2'b10
   } snpi_width_t;

   // Frame phase of the pin engine.
   typedef enum logic [1:0] {
      SNPI_PH_IDLE = 2'b00,
      SNPI_PH_IN   = 2'b01,
      SNPI_PH_OUT  = 2'b10
   } snpi_phase_t;

   localparam int          SNPI_SYNC_STAGES = 2;
   localparam int          SNPI_LANES       = 4;
   localparam logic [3:0]  SNPI_BYTE_BITS   = 4'h8;
   localparam logic [3:0]  SNPI_CNT_RESET   = 4'h0;
   localparam logic [7:0]  SNPI_BYTE_RESET  = 8'h00;
   localparam logic [3:0]  SNPI_OE_N_OFF    = 4'hF;
   localparam logic [3:0]  SNPI_OE_N_SINGLE = 4'hD;
   localparam logic [3:0]  SNPI_OE_N_DUAL   = 4'hC;
   localparam logic [3:0]  SNPI_OE_N_QUAD   = 4'h0;
   localparam int          SNPI_LANE_WP     = 2;
   localparam int          SNPI_LANE_PAUSE  = 3;

   // Number of bits moved per serial clock edge for a lane width.
   function automatic logic [3:0] snpi_bits_per_edge(input snpi_width_t w);
      unique case (w)
         SNPI_W_DUAL: snpi_bits_per_edge = 4'h2;
         SNPI_W_QUAD: snpi_bits_per_edge = 4'h4;
         default:     snpi_bits_per_edge = 4'h1;
      endcase
   endfunction : snpi_bits_per_edge

endpackage : snpi_pkg

/* core/snpi_pins_if.sv */
`timescale 1ns/1ps
// Synchronised pin levels passed from the input stage to the pin engine.
interface snpi_pins_if;
   logic       sclk;
   logic       cs_n;
   logic [3:0] lane_in;

   modport sync_side (output sclk, output cs_n, output lane_in);
   modport core_side (input sclk, input cs_n, input lane_in);
endinterface : snpi_pins_if

/* core/snpi_pin_sync.sv */
`timescale 1ns/1ps
module snpi_pin_sync
   import snpi_pkg::*;
(
   // Clock, reset and enable.
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic       ce,
   // Raw pins.
   input wire logic       spi_clk,
   input wire logic       cs_n,
   input wire logic [3:0] lane_in,
   // Synchronised levels.
   snpi_pins_if.sync_side pins
);

   logic [5:0] stage1;
   logic [5:0] stage2;
   logic [5:0] next_stage1;
   logic [5:0] next_stage2;

   // Two flip-flops per pin; chip select resets low so a high level must be seen first.
   always_comb
   begin
      next_stage1 = {spi_clk, cs_n, lane_in};
      next_stage2 = stage1;
   end

   // Registers the synchroniser stages.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         stage1 <= 6'h0F;
         stage2 <= 6'h0F;
      end
      else if (ce)
      begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   // Only the second stage leaves this module.
   assign pins.sclk    = stage2[5];
   assign pins.cs_n    = stage2[4];
   assign pins.lane_in = stage2[3:0];

endmodule : snpi_pin_sync

/* core/snpi_pin_engine.sv */
//Function
//R1 - Chip select high deselects and releases every output lane.
//R2 - After reset, nothing is accepted until chip select falls from high.
//R3 - Single lane mode captures serial input on rising serial clock edges.
//R4 - Single lane mode changes serial output on falling serial clock edges.
//R5 - Dual and quad lanes sample on rising edges and drive on falling edges.
//R6 - Lanes zero and one for single and dual; all four lanes for quad.
//R7 - Protect and pause pins act as such only outside quad operation.
//R8 - Protect pin plus protect fields guard from one block up to the array.
//R9 - Protect enable low: protect pin only guards the protection register.
//R10 - Protect enable high and pin low blocks every write, program, erase.
//R11 - Quad transfers are refused while protect enable is high.
//R12 - Pause low while selected releases output and ignores input and clock.
//R13 - Pause release resumes the transfer from the saved state.
//R14 - Once quad traffic starts, pause acts as lane three until frame end.
//R15 - The host keeps the pause pin driven high when unused.
//R16 - A started internal operation continues after chip select rises.
//R17 - Serial clock idle low or idle high at frame edges both work.
//R18 - Pause starts and ends only while serial clock is low.
//R19 - Output drivers enabled only in the data-out phase, released at deselect.
`timescale 1ns/1ps
module snpi_pin_engine
   import snpi_pkg::*;
(
   // Clock, reset and enable.
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // Device pins; lane outputs are enabled when the matching oe_n is low.
   input  wire logic       spi_clk,
   input  wire logic       cs_n,
   input  wire logic [3:0] lane_in,
   output logic      [3:0] lane_out,
   output logic      [3:0] lane_oe_n,
   // Protection configuration and results.
   input  wire logic       protect_enable,
   input  wire logic [3:0] block_protect_field,
   input  wire logic [1:0] reg_protect_field,
   output logic            write_blocked,
   output logic            reg_write_blocked,
   output logic            array_protect_active,
   // Byte stream towards the command logic.
   input  wire logic [1:0] xfer_width,
   input  wire logic       drive_out,
   input  wire logic [7:0] tx_byte,
   output logic      [7:0] rx_byte,
   output logic            rx_valid,
   output logic            rx_first,
   output logic            tx_taken,
   output logic            quad_refused,
   output logic            selected,
   output logic            paused,
   // Internal operation tracking.
   input  wire logic       op_start,
   input  wire logic       op_done,
   output logic            op_running
);

   snpi_pins_if pins ();

   snpi_pin_sync u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .ce      (ce),
      .spi_clk (spi_clk),
      .cs_n    (cs_n),
      .lane_in (lane_in),
      .pins    (pins.sync_side)
   );

   snpi_phase_t phase, next_phase;
   snpi_width_t width, next_width;
   logic        cs_prev, next_cs_prev;
   logic        clk_prev, next_clk_prev;
   logic        quad_lock, next_quad_lock;
   logic        first, next_first;
   logic [3:0]  rx_cnt, next_rx_cnt;
   logic [3:0]  tx_cnt, next_tx_cnt;
   logic [7:0]  rx_sh, next_rx_sh;
   logic [7:0]  tx_sh, next_tx_sh;
   logic [3:0]  next_lane_out, next_lane_oe_n;
   logic [7:0]  next_rx_byte;
   logic        next_rx_valid, next_rx_first, next_tx_taken;
   logic        next_quad_refused, next_paused;
   logic        wp_level, next_wp_level;
   logic        next_write_blocked, next_reg_write_blocked, next_array_protect;
   logic        next_op_running;

   // Applies the quad refusal to a requested width.
   function automatic snpi_width_t pick_width(input logic [1:0] req, input logic wpe);
      if (req == SNPI_W_QUAD && wpe)
         pick_width = SNPI_W_SINGLE; // R11
      else if (req == SNPI_W_QUAD)
         pick_width = SNPI_W_QUAD;
      else if (req == SNPI_W_DUAL)
         pick_width = SNPI_W_DUAL;
      else
         pick_width = SNPI_W_SINGLE;
   endfunction : pick_width

   // Frame, pause and shift engine.
   always_comb
   begin
      logic       rise;
      logic       fall;
      logic [3:0] step;
      logic [7:0] src;
      rise = 1'b0;
      fall = 1'b0;
      step = snpi_bits_per_edge(width);
      src  = tx_sh;
      next_phase        = phase;
      next_width        = width;
      next_cs_prev      = pins.cs_n;
      next_clk_prev     = pins.sclk;
      next_quad_lock    = quad_lock;
      next_first        = first;
      next_rx_cnt       = rx_cnt;
      next_tx_cnt       = tx_cnt;
      next_rx_sh        = rx_sh;
      next_tx_sh        = tx_sh;
      next_lane_out     = lane_out;
      next_lane_oe_n    = lane_oe_n;
      next_rx_byte      = rx_byte;
      next_rx_valid     = 1'b0;
      next_rx_first     = rx_first;
      next_tx_taken     = 1'b0;
      next_quad_refused = quad_refused;
      next_paused       = paused;
      if (pins.cs_n)
      begin
         // Deselected: lanes released; phase, width, pause and quad state reset for the next frame.
         next_phase        = SNPI_PH_IDLE; // R1
         next_lane_oe_n    = SNPI_OE_N_OFF; // R1 R19
         next_paused       = 1'b0;
         next_quad_lock    = 1'b0;
         next_quad_refused = 1'b0;
         next_width        = SNPI_W_SINGLE;
      end
      else if (phase == SNPI_PH_IDLE)
      begin
         if (cs_prev)
         begin
            // Only a seen high-to-low transition opens a frame.
            next_phase  = SNPI_PH_IN; // R2
            next_first  = 1'b1;
            next_rx_cnt = SNPI_CNT_RESET;
            next_tx_cnt = SNPI_CNT_RESET;
         end
      end
      else
      begin
         // Pause moves only while the serial clock is low, never during quad.
         if (!quad_lock && !pins.sclk) // R14 R18
         begin
            if (!paused && !pins.lane_in[SNPI_LANE_PAUSE])
               next_paused = 1'b1; // R12
            else if (paused && pins.lane_in[SNPI_LANE_PAUSE])
               next_paused = 1'b0; // R13
         end
         if (next_paused)
            next_lane_oe_n = SNPI_OE_N_OFF; // R12
         else
         begin
            // Edges compare against the last level, so mode 0 and 3 both start clean.
            rise = pins.sclk && !clk_prev; // R17
            fall = !pins.sclk && clk_prev;
            if (paused && phase == SNPI_PH_OUT)
               next_lane_oe_n = lane_oe_n_for(width); // R13
         end
         if (rise && phase == SNPI_PH_IN)
         begin
            unique case (width)
               SNPI_W_QUAD: next_rx_sh = {rx_sh[3:0], pins.lane_in}; // R5 R6
               SNPI_W_DUAL: next_rx_sh = {rx_sh[5:0], pins.lane_in[1:0]}; // R5 R6
               default:     next_rx_sh = {rx_sh[6:0], pins.lane_in[0]}; // R3
            endcase
            next_rx_cnt = rx_cnt + step;
            if (next_rx_cnt == SNPI_BYTE_BITS)
            begin
               next_rx_cnt    = SNPI_CNT_RESET;
               next_rx_byte   = next_rx_sh;
               next_rx_valid  = 1'b1;
               next_rx_first  = first;
               next_first     = 1'b0;
               next_width     = pick_width(xfer_width, protect_enable);
               next_quad_lock = quad_lock || (next_width == SNPI_W_QUAD); // R14
               next_quad_refused = quad_refused
                                   || (xfer_width == SNPI_W_QUAD && protect_enable); // R11
               if (drive_out)
                  next_phase = SNPI_PH_OUT;
            end
         end
         if (fall && phase == SNPI_PH_OUT)
         begin
            if (tx_cnt == SNPI_CNT_RESET)
            begin
               src           = tx_byte;
               next_tx_taken = 1'b1;
               next_width    = pick_width(xfer_width, protect_enable);
               next_quad_lock = quad_lock || (next_width == SNPI_W_QUAD); // R14
            end
            step = snpi_bits_per_edge(next_width);
            unique case (next_width)
               SNPI_W_QUAD: next_lane_out = src[7:4]; // R5 R6
               SNPI_W_DUAL: next_lane_out = {2'b00, src[7:6]}; // R5 R6
               default:     next_lane_out = {2'b00, src[7], 1'b0}; // R4
            endcase
            next_lane_oe_n = lane_oe_n_for(next_width); // R19
            next_tx_sh     = src << step;
            next_tx_cnt    = tx_cnt + step;
            if (next_tx_cnt == SNPI_BYTE_BITS)
               next_tx_cnt = SNPI_CNT_RESET;
         end
      end
   end

   // Output enable pattern for a lane width.
   function automatic logic [3:0] lane_oe_n_for(input snpi_width_t w);
      unique case (w)
         SNPI_W_QUAD: lane_oe_n_for = SNPI_OE_N_QUAD;
         SNPI_W_DUAL: lane_oe_n_for = SNPI_OE_N_DUAL;
         default:     lane_oe_n_for = SNPI_OE_N_SINGLE;
      endcase
   endfunction : lane_oe_n_for

   // Protection decode and internal operation tracking.
   always_comb
   begin
      next_wp_level = wp_level;
      if (!quad_lock)
         next_wp_level = pins.lane_in[SNPI_LANE_WP]; // R7
      next_write_blocked     = protect_enable && !next_wp_level; // R10
      next_reg_write_blocked = !next_wp_level
                               && (protect_enable || reg_protect_field != 2'b00); // R9
      next_array_protect     = (block_protect_field != 4'h0) || next_write_blocked; // R8
      next_op_running = op_running;
      if (op_start)
         next_op_running = 1'b1; // R16
      else if (op_done)
         next_op_running = 1'b0;
   end

   // Registers all engine and protection state.
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         phase     <= SNPI_PH_IDLE;
         width     <= SNPI_W_SINGLE;
         cs_prev   <= 1'b0;
         clk_prev  <= 1'b0;
         quad_lock <= 1'b0;
         first     <= 1'b1;
         rx_cnt    <= SNPI_CNT_RESET;
         tx_cnt    <= SNPI_CNT_RESET;
         rx_sh     <= SNPI_BYTE_RESET;
         tx_sh     <= SNPI_BYTE_RESET;
         lane_out  <= 4'h0;
         lane_oe_n <= SNPI_OE_N_OFF;
         rx_byte   <= SNPI_BYTE_RESET;
         rx_valid  <= 1'b0;
         rx_first  <= 1'b0;
         tx_taken  <= 1'b0;
         quad_refused <= 1'b0;
         selected  <= 1'b0;
         paused    <= 1'b0;
         wp_level  <= 1'b1;
         write_blocked        <= 1'b0;
         reg_write_blocked    <= 1'b0;
         array_protect_active <= 1'b0;
         op_running <= 1'b0;
      end
      else if (ce)
      begin
         phase     <= next_phase;
         width     <= next_width;
         cs_prev   <= next_cs_prev;
         clk_prev  <= next_clk_prev;
         quad_lock <= next_quad_lock;
         first     <= next_first;
         rx_cnt    <= next_rx_cnt;
         tx_cnt    <= next_tx_cnt;
         rx_sh     <= next_rx_sh;
         tx_sh     <= next_tx_sh;
         lane_out  <= next_lane_out;
         lane_oe_n <= next_lane_oe_n;
         rx_byte   <= next_rx_byte;
         rx_valid  <= next_rx_valid;
         rx_first  <= next_rx_first;
         tx_taken  <= next_tx_taken;
         quad_refused <= next_quad_refused;
         selected  <= (next_phase != SNPI_PH_IDLE);
         paused    <= next_paused;
         wp_level  <= next_wp_level;
         write_blocked        <= next_write_blocked;
         reg_write_blocked    <= next_reg_write_blocked;
         array_protect_active <= next_array_protect;
         op_running <= next_op_running; // R16
      end
   end

endmodule : snpi_pin_engine

/* tb/snpi_properties.sv */
`timescale 1ns/1ps
module snpi_properties
   import snpi_pkg::*;
(
   // Clock and reset.
   input wire logic       clock,
   input wire logic       rst_n,
   // Pins, configuration and operation strobes.
   input wire logic       cs_n,
   input wire logic [3:0] lane_in,
   input wire logic [3:0] lane_oe_n,
   input wire logic       protect_enable,
   input wire logic [3:0] block_protect_field,
   input wire logic       op_start,
   input wire logic       op_done,
   // Results.
   input wire logic       write_blocked,
   input wire logic       reg_write_blocked,
   input wire logic       array_protect_active,
   input wire logic       quad_refused,
   input wire logic       selected,
   input wire logic       paused,
   input wire logic       op_running
);
   // All checks run on the system clock and rest while reset is low.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Deselect releases the lanes and closes the frame after the synchroniser delay.
   property p_release; cs_n [*6] |-> lane_oe_n == SNPI_OE_N_OFF; endproperty
   a_release: assert property (p_release) else $error("lanes driven while deselected");
   property p_desel; cs_n [*6] |-> !selected; endproperty
   a_desel: assert property (p_desel) else $error("frame open while deselected");
   // Protection outputs follow the protect pin and the enable bit.
   property p_nowblk; !protect_enable |=> !write_blocked; endproperty
   a_nowblk: assert property (p_nowblk) else $error("blocked with enable low");
   property p_wblk; (protect_enable && !lane_in[2] && cs_n) [*8] |-> write_blocked; endproperty
   a_wblk: assert property (p_wblk) else $error("writes not blocked");
   property p_rwblk; (lane_in[2] && cs_n) [*8] |-> !reg_write_blocked; endproperty
   a_rwblk: assert property (p_rwblk) else $error("register blocked with pin high");
   property p_arr; block_protect_field != 4'h0 |=> array_protect_active; endproperty
   a_arr: assert property (p_arr) else $error("array protection missing");
   // A refused quad request never drives four lanes.
   property p_qref; $rose(quad_refused) |-> $past(protect_enable); endproperty
   a_qref: assert property (p_qref) else $error("quad refused without enable");
   property p_qoe; quad_refused |-> lane_oe_n != SNPI_OE_N_QUAD; endproperty
   a_qoe: assert property (p_qoe) else $error("quad lanes driven while refused");
   // A pause in force releases every lane.
   property p_pause; paused [*2] |-> lane_oe_n == SNPI_OE_N_OFF; endproperty
   a_pause: assert property (p_pause) else $error("lanes driven during pause");
   // A running operation only stops on its done strobe, whatever select does.
   property p_op_hold; op_running && !op_done && !op_start |=> op_running; endproperty
   a_op_hold: assert property (p_op_hold) else $error("operation dropped");
endmodule : snpi_properties

bind snpi_pin_engine snpi_properties i_snpi_properties (.clock(clock), .rst_n(rst_n),
   .cs_n(cs_n), .lane_in(lane_in), .lane_oe_n(lane_oe_n), .protect_enable(protect_enable),
   .block_protect_field(block_protect_field), .op_start(op_start), .op_done(op_done),
   .write_blocked(write_blocked), .reg_write_blocked(reg_write_blocked),
   .array_protect_active(array_protect_active), .quad_refused(quad_refused),
   .selected(selected), .paused(paused), .op_running(op_running));

/* tb/snpi_host.sv */
`timescale 1ns/1ps
module snpi_host
(
   // Link pins driven towards the device.
   output logic           spi_clk,
   output logic           cs_n,
   output logic     [3:0] lane_in,
   // Device lane drivers, low enable means driving.
   input  wire logic [3:0] lane_out,
   input  wire logic [3:0] lane_oe_n
);
   logic [3:0] hval;
   logic [3:0] hdrv;
   logic       wp;
   logic       ps;
   logic       tog;

   // Select starts low, so the device has not yet seen it high.
   initial
   begin
      spi_clk = 1'b0;
      cs_n = 1'b0;
      hval = 4'hC;
      hdrv = 4'hC;
      wp = 1'b1;
      ps = 1'b1;
      tog = 1'b0;
   end

   // A lane nobody drives shows a pattern that changes every system cycle.
   always #8 tog = ~tog;

   // Each wire carries the device when it drives, else the host, else noise.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         lane_in[i] = !lane_oe_n[i] ? lane_out[i] : (hdrv[i] ? hval[i] : tog);
      end
   end

   // Sets the protect and pause pin levels outside quad traffic.
   task automatic pins(input logic p, input logic h);
      wp = p;
      ps = h;
      hval[3:2] = {h, p};
   endtask : pins

   // Opens a frame; in mode 3 the clock idles high at the select edge.
   task automatic open_f(input logic mode3);
      spi_clk = mode3;
      #40 cs_n = 1'b0;
      #40 spi_clk = 1'b0;
   endtask : open_f

   // Closes a frame and leaves the clock standing at its idle level.
   task automatic close_f(input logic mode3);
      #40 spi_clk = mode3;
      #40 cs_n = 1'b1;
      hdrv = 4'hC;
   endtask : close_f

   // Moves bits MSB first over e edges; a read releases the data lanes.
   task automatic xbyte(input logic [7:0] tx, input logic [1:0] w, input logic rd,
                        input int e, output logic [7:0] rx);
      int         n;
      logic [3:0] m;
      n = (w == 2'h2) ? 4 : ((w == 2'h1) ? 2 : 1);
      m = 4'((1 << n) - 1);
      rx = 8'h00;
      hdrv = rd ? (4'hC & ~m) : (4'hC | m);
      repeat (e)
      begin
         hval = (hval & ~m) | (4'(tx >> (8 - n)) & m);
         tx = tx << n;
         #40 spi_clk = 1'b1;
         rx = (rx << n) | ((n == 1) ? 8'(lane_in[1]) : 8'(lane_in & m));
         #40 spi_clk = 1'b0;
      end
      hdrv[3:2] = 2'b11;
      hval[3:2] = {ps, wp};
   endtask : xbyte
endmodule : snpi_host

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        clock;
   logic        rst_n;
   logic        ce;
   logic        spi_clk, cs_n, write_blocked, reg_write_blocked, array_protect_active;
   logic [3:0]  lane_in, lane_out, lane_oe_n;
   logic        protect_enable;
   logic [3:0]  block_protect_field;
   logic [1:0]  reg_protect_field;
   logic [1:0]  xfer_width;
   logic        drive_out;
   logic [7:0]  tx_byte;
   logic [7:0]  rx_byte;
   logic        rx_valid, rx_first, tx_taken, quad_refused, selected, paused, op_running;
   logic        op_start;
   logic        op_done;
   logic        fx;
   logic [8:0]  rx_exp;
   logic [15:0] lfsr;
   logic [8:0]  rxq[$];
   int          fail_count = 0;
   int          n_tests = 0;
   int          cycles = 0;
   int          n_taken = 0;

   // Device under test and the host on its link.
   snpi_pin_engine i_snpi_pin_engine (.clock, .rst_n, .ce, .spi_clk, .cs_n, .lane_in,
      .lane_out, .lane_oe_n, .protect_enable, .block_protect_field, .reg_protect_field,
      .write_blocked, .reg_write_blocked, .array_protect_active, .xfer_width, .drive_out,
      .tx_byte, .rx_byte, .rx_valid, .rx_first, .tx_taken, .quad_refused, .selected,
      .paused, .op_start, .op_done, .op_running);
   snpi_host i_snpi_host (.spi_clk, .cs_n, .lane_in, .lane_out, .lane_oe_n);

   // System clock at 125 MHz.
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report

   // Compare tasks for bytes and for single flags.
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // Pseudo-random bytes from a 16-bit shift register.
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd
   function automatic int edges(input logic [1:0] w);
      return (w == 2'h2) ? 2 : ((w == 2'h1) ? 4 : 8);
   endfunction : edges

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc

   // Sends one byte and notes it as an expected reception.
   task automatic send(input logic [7:0] b, input logic [1:0] w);
      logic [7:0] r;
      rxq.push_back({fx, b});
      fx = 1'b0;
      i_snpi_host.xbyte(b, w, 1'b0, edges(w), r);
   endtask : send

   // One read frame: instruction, then one byte out at the expected width.
   task automatic rd_frame(input logic [1:0] w, input logic [1:0] wexp);
      logic [7:0] t;
      logic [7:0] r;
      t = rnd();
      tx_byte = t;
      n_taken = 0;
      drive_out = 1'b1;
      xfer_width = w;
      i_snpi_host.open_f(1'b0);
      send(rnd(), 2'h0);
      i_snpi_host.xbyte(8'h00, wexp, 1'b1, edges(wexp), r);
      chk_byte(r, t);
      chk_bit(quad_refused, protect_enable & (w == 2'h2));
      i_snpi_host.close_f(1'b0);
      chk_byte(8'(n_taken), 8'h02);
      drive_out = 1'b0;
      cyc(8);
   endtask : rd_frame

   // Each received byte is matched against the oldest byte sent.
   always @(posedge clock)
   begin
      if (rx_valid === 1'b1)
      begin
         rx_exp = (rxq.size() > 0) ? rxq.pop_front() : ~{rx_first, rx_byte};
         chk_byte(rx_byte, rx_exp[7:0]);
         chk_bit(rx_first, rx_exp[8]);
      end
   end

   // A falling select marks the next byte sent as the frame's first.
   always @(negedge cs_n)
      fx = 1'b1;

   // Counts the output byte loads reported on the stream side.
   always @(posedge clock)
   begin
      if (tx_taken === 1'b1)
         n_taken++;
   end

   // Cuts a hung run short.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         fail_count++;
         final_report();
      end
   end

   // Main sequence.
   initial
   begin
      logic [7:0] r;
      logic [7:0] x;
      rst_n = 1'b0;
      ce = 1'b1;
      protect_enable = 1'b0;
      block_protect_field = 4'h0;
      reg_protect_field = 2'h0;
      xfer_width = 2'h0;
      drive_out = 1'b0;
      tx_byte = 8'h00;
      op_start = 1'b0;
      op_done = 1'b0;
      fx = 1'b0;
      lfsr = 16'hD996;
      repeat (6) @(posedge clock);
      #1 rst_n = 1'b1;
      i_snpi_host.xbyte(rnd(), 2'h0, 1'b0, 8, r);
      i_snpi_host.close_f(1'b0);
      cyc(8);
      $display("test select_first done");
      xfer_width = 2'h1;
      i_snpi_host.open_f(1'b0);
      send(rnd(), 2'h0);
      xfer_width = 2'h2;
      send(rnd(), 2'h1);
      send(8'h36, 2'h2);
      i_snpi_host.close_f(1'b0);
      cyc(8);
      $display("test write_widths done");
      for (int w = 0; w < 3; w++)
         rd_frame(2'(w), 2'(w));
      protect_enable = 1'b1;
      rd_frame(2'h2, 2'h0);
      protect_enable = 1'b0;
      $display("test read_widths done");
      xfer_width = 2'h0;
      i_snpi_host.open_f(1'b1);
      send(rnd(), 2'h0);
      send(rnd(), 2'h0);
      i_snpi_host.close_f(1'b1);
      cyc(8);
      $display("test mode3 done");
      x = rnd();
      i_snpi_host.open_f(1'b0);
      rxq.push_back({fx, x});
      fx = 1'b0;
      i_snpi_host.xbyte(x, 2'h0, 1'b0, 4, r);
      i_snpi_host.pins(1'b1, 1'b0);
      cyc(6);
      chk_bit(paused, 1'b1);
      i_snpi_host.xbyte(rnd(), 2'h0, 1'b0, 3, r);
      i_snpi_host.pins(1'b1, 1'b1);
      cyc(6);
      chk_bit(paused, 1'b0);
      i_snpi_host.xbyte(x << 4, 2'h0, 1'b0, 4, r);
      i_snpi_host.close_f(1'b0);
      cyc(8);
      $display("test pause done");
      for (int i = 0; i < 8; i++)
      begin
         block_protect_field = i[2] ? 4'(rnd()) : 4'h0;
         reg_protect_field = 2'(rnd());
         protect_enable = i[0];
         i_snpi_host.pins(i[1], 1'b1);
         cyc(6);
         chk_bit(write_blocked, i[0] & !i[1]);
         chk_bit(reg_write_blocked, !i[1] & (i[0] | (reg_protect_field != 2'h0)));
         chk_bit(array_protect_active, (block_protect_field != 4'h0) | (i[0] & !i[1]));
      end
      ce = 1'b0;
      i_snpi_host.pins(1'b0, 1'b1);
      cyc(4);
      chk_bit(write_blocked, 1'b0);
      ce = 1'b1;
      cyc(6);
      chk_bit(write_blocked, 1'b1);
      protect_enable = 1'b0;
      i_snpi_host.pins(1'b1, 1'b1);
      $display("test protection done");
      i_snpi_host.open_f(1'b0);
      op_start = 1'b1;
      cyc(1);
      op_start = 1'b0;
      i_snpi_host.close_f(1'b0);
      cyc(10);
      chk_bit(op_running, 1'b1);
      op_done = 1'b1;
      cyc(1);
      op_done = 1'b0;
      cyc(2);
      chk_bit(op_running, 1'b0);
      $display("test operation done");
      final_report();
   end
endmodule : tb
